/* dv/fpsw_ctrl_props.sv */
// fpsw_ctrl_props.sv: port checks for fpsw_ctrl
// assumes: bound to fpsw_ctrl, one pclk domain
`timescale 1ns/1ps
module fpsw_ctrl_props (
   // apb
   input wire        pclk,
   input wire        presetn,
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [3:0]  pstrb,
   input wire [31:0] prdata,
   input wire        pready,
   input wire        pslverr,
   // function side
   input wire        wake_source,
   input wire        card_status_change_line,
   input wire [1:0]  power_state_field,
   input wire        d0_active
);
   wire acc = psel && penable;
   wire csr = acc && pwrite && paddr == 12'h004;
   wire rd  = acc && !pwrite;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   bus_ok_a: assert property (acc |-> pready && !pslverr) else $error("bad bus end");
   settle_a: assert property (csr && pstrb[0] |=> $stable(power_state_field) [*8])
      else $error("early state");
   // outside d0 a raised line stays up until a write clears status or enable
   hold_a: assert property (card_status_change_line && power_state_field != 2'h0
      && !(csr && pstrb[1] && (pwdata[15] || !pwdata[8])) |=> card_status_change_line) else $error("line dropped");
   active_a: assert property ($rose(d0_active) |-> power_state_field == 2'h0) else $error("active off d0");
   reset_a: assert property ($rose(presetn) |-> power_state_field == 2'h0) else $error("reset state");
   cap_a: assert property (rd && paddr == 12'h000 |-> prdata[15:9] == 7'h7f && prdata[2:0] == 3'h3)
      else $error("bad cap");
   csr_a: assert property (rd && paddr == 12'h004 |-> prdata[1:0] == $past(power_state_field))
      else $error("bad csr");
   cause_a: assert property ($rose(card_status_change_line) |-> $past(wake_source) || $past(wake_source, 2))
      else $error("line uncaused");
   cover property ($rose(card_status_change_line));
   cover property ($rose(d0_active));
   cover property (power_state_field == 2'h3);
endmodule // fpsw_ctrl_props

/* dv/fpsw_host_bridge.sv */
// fpsw_host_bridge.sv: host bridge model, card wake line to system request
// assumes: shares pclk with the function
`timescale 1ns/1ps
module fpsw_host_bridge (
   // clock
   input wire   pclk,
   // card and system side
   input wire   card_status_change_line,
   output logic wake_req_n
);
   // no latch: an early drop just ends the request, no error
   always @(posedge pclk) begin
      wake_req_n <= ~card_status_change_line;
   end
endmodule // fpsw_host_bridge

/* dv/test_function_power_state_wake_control.sv */
// test_function_power_state_wake_control.sv: directed bench for fpsw_ctrl
// assumes: props and host bridge model compiled first
`timescale 1ns/1ps
module test_function_power_state_wake_control;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, wake_source = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, rd;
   logic [3:0]  pstrb = 4'h0;
   wire  [31:0] prdata;
   wire  [1:0]  power_state_field;
   wire         pready, pslverr, card_status_change_line, d0_active, wake_req_n;
   int          n_fail = 0, checked = 0;
   always #10 pclk = ~pclk;
   fpsw_ctrl u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
      .pslverr, .wake_source, .card_status_change_line, .power_state_field, .d0_active);
   fpsw_host_bridge u_host (.pclk, .card_status_change_line, .wake_req_n);
   task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task close_out;
      $display("mismatches %0d, comparisons %0d", n_fail, checked);
      if (n_fail == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // state write, then the settling wait
   task go(input logic [31:0] d);
      apb(1'b1, 12'h004, d, 4'h3);
      repeat (14) @(posedge pclk);
   endtask
   task t_states;
      logic [1:0] s;
      chk("reset state", power_state_field, 32'h0);
      apb(1'b0, 12'h000, 32'h0, 4'h0);
      chk("cap", rd[15:0] & 16'hfe27, 16'hfe03);
      for (int i = 1; i < 5; i++) begin
         s = i[1:0];
         go({30'h0, s});
         chk("state", power_state_field, s);
         apb(1'b0, 12'h004, 32'h0, 4'h0);
         chk("csr state", rd[1:0], s);
      end
   endtask
   task t_active;
      apb(1'b1, 12'h008, 32'h3, 4'h1);
      repeat (3) @(posedge pclk);
      chk("partial", d0_active, 1'b0);
      apb(1'b1, 12'h008, 32'h7, 4'h1);
      repeat (3) @(posedge pclk);
      apb(1'b0, 12'h010, 32'h0, 4'h0);
      chk("active", {rd[4], d0_active}, 2'h3);
      go(32'h3);
      apb(1'b0, 12'h008, 32'h0, 4'h0);
      chk("d3 off", {rd[2:0], d0_active}, 4'h0);
   endtask
   task t_wake;
      apb(1'b1, 12'h004, 32'h103, 4'h2);
      wake_source <= 1'b1;
      @(posedge pclk);
      wake_source <= 1'b0;
      repeat (4) @(posedge pclk);
      chk("line", {card_status_change_line, wake_req_n}, 2'h2);
      apb(1'b1, 12'h004, 32'h103, 4'h2);
      apb(1'b0, 12'h004, 32'h0, 4'h0);
      chk("held", {card_status_change_line, rd[15]}, 2'h3);
      apb(1'b1, 12'h004, 32'h8103, 4'h2);
      repeat (2) @(posedge pclk);
      chk("cleared", card_status_change_line, 1'b0);
      apb(1'b0, 12'h020, 32'h0, 4'h0);
      chk("unmapped", rd, 32'h0);
      go(32'h0);
      apb(1'b1, 12'h008, 32'h7, 4'h1);
   endtask
   // segment reset out of d3, then full reinit back to the active sub-state
   task t_reinit;
      go(32'h3);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      chk("reset low", {card_status_change_line, power_state_field, d0_active}, 4'h0);
      presetn <= 1'b1;
      apb(1'b1, 12'h008, 32'h7, 4'h1);
      repeat (3) @(posedge pclk);
      chk("reinit", d0_active, 1'b1);
   endtask
   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      t_states;
      t_active;
      t_wake;
      t_reinit;
      close_out;
   end
   // run is under two hundred cycles
   initial begin
      #20us;
      n_fail++;
      close_out;
   end
endmodule // test_function_power_state_wake_control
bind fpsw_ctrl fpsw_ctrl_props u_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
   .prdata, .pready, .pslverr, .wake_source, .card_status_change_line, .power_state_field, .d0_active);

/* hw/fpsw_ctrl.v */
// fpsw_ctrl.v: power-state, d0 sub-state and wake-event logic of one card function
// assumes: apb master on pclk, wake source synchronous to pclk, host bridge
// translates the status-change line into the system wake request
`timescale 1ns/1ps
`include "fpsw_defs.vh"

// Function
// - wake shown on status-change line
// - d0 active once mem, io, master enabled
// - status bits change only after completion
// - capability and control/status readable
// - four states written, only supported accepted
// - wake held until status or enable cleared
// - wake status clears only on written one, wake enable takes the written value
// - unsupported state write ignored, completes normally
module fpsw_ctrl (
   // apb clock and reset
   input  wire        pclk,
   input  wire        presetn,
   // apb slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   input  wire [3:0]  pstrb,
   output reg  [31:0] prdata,
   output wire        pready,
   output wire        pslverr,
   // function side
   input  wire        wake_source,
   output reg         card_status_change_line,
   output reg  [1:0]  power_state_field,
   output reg         d0_active
);

   localparam [2:0] ST_IDLE   = 3'b001;
   localparam [2:0] ST_SETTLE = 3'b010;
   localparam [2:0] ST_CHECK  = 3'b100;
   localparam [7:0] SETTLE_CYC = `FPSW_SETTLE_CYC;

   reg  [2:0]  state;
   reg  [1:0]  target_state;
   reg  [7:0]  settle_cnt;
   reg         wake_enable_bit;
   reg         wake_status_bit;
   reg  [2:0]  cmd_bits;
   reg         next_wake_status;
   reg         next_wake_enable;
   reg         next_change;
   reg  [31:0] next_rdata;
   reg  [2:0]  next_state;
   reg  [1:0]  next_target;
   reg  [7:0]  next_settle;
   reg  [1:0]  next_field;
   reg  [2:0]  next_cmd;
   reg         next_active;
   reg         req_ok;

   wire        wr_access;
   wire        rd_access;
   wire        csr_wr;
   wire        cmd_wr;
   wire [1:0]  req_state;
   wire [31:0] power_capability_reg;
   wire [31:0] power_control_status_reg;
   wire        mapped;
   wire        state_wr;
   wire        wake_wr;
   wire        wake_off;
   wire        busy;
   wire        entering_d3;
   wire        all_enabled;
   wire [4:0]  slot_hit;
   wire [59:0] slot_off;

   genvar      gi;

   assign pready    = 1'b1;
   assign pslverr   = 1'b0;
   assign wr_access = psel & penable & pwrite;
   assign rd_access = psel & ~penable & ~pwrite;
   assign csr_wr    = wr_access & (paddr == `FPSW_OFF_CSR);
   assign cmd_wr    = wr_access & (paddr == `FPSW_OFF_CMD);
   assign req_state = pwdata[`FPSW_CSR_PS_MSB:`FPSW_CSR_PS_LSB];

   assign state_wr    = csr_wr & pstrb[0];
   assign wake_wr     = csr_wr & pstrb[1];
   // a write that clears status or enable releases the line
   assign wake_off    = wake_wr & (pwdata[`FPSW_CSR_WST] | ~pwdata[`FPSW_CSR_WEN]);
   assign busy        = (state != ST_IDLE);
   assign entering_d3 = (state == ST_CHECK) & (target_state == `FPSW_D3);
   assign all_enabled = cmd_bits[`FPSW_CMD_IO] & cmd_bits[`FPSW_CMD_MEM] & cmd_bits[`FPSW_CMD_MST];

   // one hit line per register slot; unmapped offsets read as zero
   assign slot_off = {`FPSW_OFF_STAT, `FPSW_OFF_EVT, `FPSW_OFF_CMD, `FPSW_OFF_CSR, `FPSW_OFF_CAP};
   generate
      for (gi = 0; gi < 5; gi = gi + 1) begin : g_slot
         assign slot_hit[gi] = (paddr == slot_off[gi*12 +: 12]);
      end
   endgenerate
   assign mapped = |slot_hit;

   // d0 and d3 are always supported; d1/d2 per capability
   always @* begin
      case (req_state)
         `FPSW_D0: req_ok = 1'b1;
         `FPSW_D1: req_ok = `FPSW_SUP_D1;
         `FPSW_D2: req_ok = `FPSW_SUP_D2;
         `FPSW_D3: req_ok = 1'b1;
         default:  req_ok = 1'b0;
      endcase
   end

   assign power_capability_reg = {16'h0000,
                                  `FPSW_WAKE_SUP,
                                  `FPSW_SUP_D2,
                                  `FPSW_SUP_D1,
                                  3'h0,
                                  `FPSW_SUP_DSI,
                                  5'h03};

   assign power_control_status_reg = {16'h0000,
                                      wake_status_bit,
                                      6'h00,
                                      wake_enable_bit,
                                      6'h00,
                                      power_state_field};

   // state change: the field only moves after settling completes
   always @* begin
      next_state  = state;
      next_target = target_state;
      next_settle = settle_cnt;
      next_field  = power_state_field;
      case (state)
         ST_IDLE: begin
            // a low-byte strobe is needed to touch the state field
            if (state_wr && req_ok && (req_state != power_state_field)) begin
               next_target = req_state;
               next_settle = SETTLE_CYC;
               next_state  = ST_SETTLE;
            end
            // unsupported request: write completes, state untouched
         end
         ST_SETTLE: begin
            next_settle = settle_cnt - 8'h01;
            if (settle_cnt == 8'h01) begin
               next_state = ST_CHECK;
            end
         end
         ST_CHECK: begin
            // software reads the old state until the change is done
            next_field = target_state;
            next_state = ST_IDLE;
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state             <= ST_IDLE;
         target_state      <= `FPSW_PS_RST;
         settle_cnt        <= 8'h00;
         power_state_field <= `FPSW_PS_RST;
      end else begin
         state             <= next_state;
         target_state      <= next_target;
         settle_cnt        <= next_settle;
         power_state_field <= next_field;
      end
   end

   // command enables, cleared on entry to d3 since context is lost there
   always @* begin
      next_cmd = cmd_bits;
      if (entering_d3) begin
         next_cmd = 3'h0;
      end else if (cmd_wr && pstrb[0]) begin
         next_cmd = pwdata[2:0];
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmd_bits <= 3'h0;
      end else begin
         cmd_bits <= next_cmd;
      end
   end

   // d0 sub-state: active only when all three enables are set in d0
   always @* begin
      next_active = 1'b0;
      if ((power_state_field == `FPSW_D0) && !busy) begin
         next_active = all_enabled;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         d0_active <= 1'b0;
      end else begin
         d0_active <= next_active;
      end
   end

   // wake bits: enable is a plain bit, status is write-one-to-clear
   always @* begin
      next_wake_enable = wake_enable_bit;
      next_wake_status = wake_status_bit;
      if (wake_wr) begin
         next_wake_enable = pwdata[`FPSW_CSR_WEN];
      end
      if (wake_wr && pwdata[`FPSW_CSR_WST]) begin
         next_wake_status = 1'b0;
      end
      // set wins over a clear in the same cycle, so no event is lost
      if (wake_source && wake_enable_bit) begin
         next_wake_status = 1'b1;
      end
   end

   // outside d0 only an enabled, latched event may drive the line
   always @* begin
      if (power_state_field == `FPSW_D0) begin
         next_change = (wake_status_bit & wake_enable_bit) | wake_source;
      end else begin
         next_change = wake_status_bit & wake_enable_bit;
      end
      if (wake_off) begin
         next_change = wake_source & (power_state_field == `FPSW_D0);
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wake_enable_bit         <= 1'b0;
         wake_status_bit         <= 1'b0;
         card_status_change_line <= 1'b0;
      end else begin
         wake_enable_bit         <= next_wake_enable;
         wake_status_bit         <= next_wake_status;
         card_status_change_line <= next_change;
      end
   end

   // read data registered in the setup phase
   always @* begin
      next_rdata = 32'h0000_0000;
      case (paddr)
         `FPSW_OFF_CAP: begin
            next_rdata = power_capability_reg;
         end
         `FPSW_OFF_CSR: begin
            next_rdata = power_control_status_reg;
         end
         `FPSW_OFF_CMD: begin
            next_rdata = {29'h0, cmd_bits};
         end
         `FPSW_OFF_EVT: begin
            next_rdata = {31'h0, card_status_change_line};
         end
         `FPSW_OFF_STAT: begin
            // busy lets software poll instead of counting settle cycles
            next_rdata = {27'h0, d0_active, busy, 1'b0, target_state};
         end
         default: begin
            next_rdata = 32'h0000_0000;
         end
      endcase
      if (!mapped) begin
         next_rdata = 32'h0000_0000;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (rd_access) begin
         prdata <= next_rdata;
      end
   end

endmodule // fpsw_ctrl

/* hw/fpsw_defs.vh */
// fpsw_defs.vh: register offsets, field positions, reset values and timing counts
// assumes: included by fpsw_ctrl.v only, by bare name
`ifndef FPSW_DEFS_VH
`define FPSW_DEFS_VH

// register byte offsets on apb
`define FPSW_OFF_CAP        12'h000
`define FPSW_OFF_CSR        12'h004
`define FPSW_OFF_CMD        12'h008
`define FPSW_OFF_EVT        12'h00c
`define FPSW_OFF_STAT       12'h010

// power control/status register fields
`define FPSW_CSR_PS_LSB     0
`define FPSW_CSR_PS_MSB     1
`define FPSW_CSR_WEN        8
`define FPSW_CSR_WST        15

// power capability register fields
`define FPSW_CAP_DSI        5
`define FPSW_CAP_D1         9
`define FPSW_CAP_D2         10
`define FPSW_CAP_WAKE_LSB   11
`define FPSW_CAP_WAKE_MSB   15

// command register fields
`define FPSW_CMD_IO         0
`define FPSW_CMD_MEM        1
`define FPSW_CMD_MST        2

// power state encodings
`define FPSW_D0             2'h0
`define FPSW_D1             2'h1
`define FPSW_D2             2'h2
`define FPSW_D3             2'h3

// reset values and supported features
`define FPSW_PS_RST         2'h0
`define FPSW_SUP_D1         1'b1
`define FPSW_SUP_D2         1'b1
`define FPSW_SUP_DSI        1'b0
`define FPSW_WAKE_SUP       5'h1f

// settling time of a state change, ns, and the cycle count at 50 MHz
`define FPSW_SETTLE_NS      200
`define FPSW_CLK_NS         20
`define FPSW_SETTLE_CYC     ((`FPSW_SETTLE_NS + `FPSW_CLK_NS - 1) / `FPSW_CLK_NS)

`endif
